// [bert_cfg.svh]
// register offsets, field positions, reset values and counts of the bit error rate tester
// assumes: included by bare name from the top module and the bench
`ifndef BERT_CFG_SVH
`define BERT_CFG_SVH

// ************************************************
// byte offsets on the register bus
// ************************************************
`define BERT_OFS_PATSET 8'h00
`define BERT_OFS_PATLEN 8'h04
`define BERT_OFS_TAP 8'h08
`define BERT_OFS_CTRL 8'h0C
`define BERT_OFS_ERRINS 8'h10
`define BERT_OFS_STATUS 8'h14
`define BERT_OFS_RXPAT 8'h18
`define BERT_OFS_ERRCNT 8'h1C
`define BERT_OFS_BITCNT 8'h20

// ************************************************
// field positions and reset values
// ************************************************
`define BERT_ST_SYNC 0
`define BERT_ST_ONES 1
`define BERT_ST_ZEROS 2
`define BERT_EI_SINGLE 3
`define BERT_RST_PATSET 32'h0000_0000
`define BERT_RST_LEN 5'h00
`define BERT_RST_CTRL 8'h00
`define BERT_RST_EI 4'h0
`define BERT_RST_HIST 32'h5555_5555

// ************************************************
// sequence counts
// ************************************************
`define BERT_TX_LOAD_EDGES 2'h3
`define BERT_SYNC_BASE 7'h22
`define BERT_LOSS_WINDOW 6'h3F
`define BERT_LOSS_ERRORS 3'h6
`define BERT_DEC1 24'h00_000A
`define BERT_DEC2 24'h00_0064
`define BERT_DEC3 24'h00_03E8
`define BERT_DEC4 24'h00_2710
`define BERT_DEC5 24'h01_86A0
`define BERT_DEC6 24'h0F_4240
`define BERT_DEC7 24'h98_9680

`endif

// [bert_pkg.sv]
// types shared by the bit error rate tester
// assumes: nothing beyond the constants header
package bert_pkg;
	// pattern control register layout, bit 7 first
	typedef struct packed {
		logic txLoad;
		logic [2:0] spare;
		logic loadCount;
		logic resync;
		logic syncEnable;
		logic repMode;
	} bert_ctrl_t;

	// latched address phase of one bus transfer
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} bert_req_t;

	typedef enum logic {BERT_HUNT, BERT_LOCKED} bert_rx_state_t;
endpackage : bert_pkg

// [bert_sync2.sv]
// two-flop synchroniser for a group of asynchronous levels
// assumes: one clock, reset already released synchronously by the caller
`timescale 1ns/1ps
`default_nettype none
module bert_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // sampling clock
	input wire logic rst_n, // reset, active low
	input wire logic [WIDTH-1:0] asyncIn, // levels from outside
	output logic [WIDTH-1:0] syncOut // levels in clk domain
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : bert_sync2
`default_nettype wire

// [bert_top.sv]
// bit error rate tester: pattern generator, receiver with synchroniser, bit and error counters
// assumes: AHB-Lite single word transfers, bit clocks well below half of ref_clk
//
// How it works
// - pseudorandom generator with programmable length and tap, up to 32 bits
// - repetitive mode repeats a programmed pattern of 1 to 32 bits
// - error count and bit count held in two readable 32-bit counters
// - after programming, a transmit load starts the pattern at the serial output
// - receiver hunts for the pattern, steered by sync enable and resync bits
// - pseudorandom check against transmit polynomial; all zeros also pass, all ones do not
// - all-ones and all-zeros reception reported as status flags for software
// - sync declared after 34 plus n consecutive error-free bits
// - status bit zero high while synced; each deviating bit while synced counts an error
// - repetitive mode syncs on any pattern of the same length; pattern readable
// - load count marks the integration period; software divides errors by bits
// - transmitter inverts a single bit or one in ten up to one in ten million
// - first tap always at length minus one, second tap programmable
// - both paths work at any bit clock rate from static up to well below half of ref_clk
// - transmit and receive run independently with their own pattern state
// - receiver stays synced with error rates up to one in a hundred
// - gapped bit clocks: only clocked bit periods carry pattern data
// - load edge fills generator; first bit, msb first, after third clock edge
// - transmit load pin ORed with control bit 7
`timescale 1ns/1ps
`default_nettype none
`include "bert_cfg.svh"
module bert_top
	import bert_pkg::*;
(
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire logic transmitLoad, // load pin, rising edge
	input wire logic loadCount, // integration boundary pin
	input wire logic txBitClock, // transmit bit clock pin
	input wire logic rxBitClock, // receive bit clock pin
	input wire logic rxData, // serial receive data
	output logic txData, // serial transmit data
	output logic rxSync // receiver in sync
);
	// ************************************************
	// reset release and pin synchronisers
	// ************************************************
	logic [1:0] rstPipe_q;
	logic rstSync_n;
	logic [4:0] pinS;
	logic txClkS, rxClkS, rxDatS, loadPinS, lcPinS;

	// async assert, two-flop release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rstPipe_q <= 2'h0;
		else rstPipe_q <= {rstPipe_q[0], 1'b1};
	end
	assign rstSync_n = rstPipe_q[1];

	bert_sync2 #(.WIDTH(5)) uPins (
		.clk(ref_clk),
		.rst_n(rstSync_n),
		.asyncIn({txBitClock, rxBitClock, rxData, transmitLoad, loadCount}),
		.syncOut(pinS)
	);
	assign {txClkS, rxClkS, rxDatS, loadPinS, lcPinS} = pinS;

	// ************************************************
	// register bus slave
	// ************************************************
	logic [31:0] patSet_q, errCnt_q, bitCnt_q, rxSr_q;
	logic [4:0] patLen_q, tap_q;
	bert_ctrl_t ctrl_q;
	logic [3:0] errIns_q;
	logic singlePend_q;
	bert_req_t req_q;
	logic [31:0] rdData_q;
	logic wrEn, ctrlWr, addrPhase;
	logic [31:0] statusWord;
	bert_rx_state_t rxState_q;
	logic onesFlag_q, zerosFlag_q;

	// zero wait states: every transfer ends in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_q;
	assign addrPhase = hsel && hready && htrans[1];
	assign wrEn = req_q.valid && req_q.write;
	assign ctrlWr = wrEn && req_q.addr == `BERT_OFS_CTRL;
	assign statusWord = {29'h0, zerosFlag_q, onesFlag_q, rxState_q == BERT_LOCKED};

	// address phase capture
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) req_q <= '0;
		else req_q <= '{valid: addrPhase, write: hwrite, addr: haddr[7:0]};
	end

	// read data registered at the address phase, unmapped reads give zero
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rdData_q <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			unique case (haddr[7:0])
				`BERT_OFS_PATSET: rdData_q <= patSet_q;
				`BERT_OFS_PATLEN: rdData_q <= {27'h0, patLen_q};
				`BERT_OFS_TAP: rdData_q <= {27'h0, tap_q};
				// pulse bits read as zero, even in the cycle right after their write
				`BERT_OFS_CTRL: rdData_q <= {24'h0, ctrl_q.txLoad, ctrl_q.spare, 2'h0, ctrl_q.syncEnable, ctrl_q.repMode};
				`BERT_OFS_ERRINS: rdData_q <= {29'h0, errIns_q[2:0]};
				`BERT_OFS_STATUS: rdData_q <= statusWord;
				`BERT_OFS_RXPAT: rdData_q <= rxSr_q;
				`BERT_OFS_ERRCNT: rdData_q <= errCnt_q;
				`BERT_OFS_BITCNT: rdData_q <= bitCnt_q;
				default: rdData_q <= 32'h0000_0000;
			endcase
		end
	end

	// programming registers; resync and load count bits are write pulses
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			patSet_q <= `BERT_RST_PATSET;
			patLen_q <= `BERT_RST_LEN;
			tap_q <= `BERT_RST_LEN;
			ctrl_q <= `BERT_RST_CTRL;
			errIns_q <= `BERT_RST_EI;
		end else begin
			ctrl_q.resync <= 1'b0;
			ctrl_q.loadCount <= 1'b0;
			errIns_q[`BERT_EI_SINGLE] <= 1'b0;
			if (wrEn) begin
				unique case (req_q.addr)
					`BERT_OFS_PATSET: patSet_q <= hwdata;
					`BERT_OFS_PATLEN: patLen_q <= hwdata[4:0];
					`BERT_OFS_TAP: tap_q <= hwdata[4:0];
					`BERT_OFS_CTRL: ctrl_q <= hwdata[7:0];
					`BERT_OFS_ERRINS: errIns_q <= hwdata[3:0];
					default: ;
				endcase
			end
		end
	end

	// ************************************************
	// transmit generator
	// ************************************************
	logic txClkP_q, loadReqP_q, txEdge, loadEdge, fire, inject;
	logic [1:0] txArm_q;
	logic txRun_q;
	logic [31:0] txSr_q, lenMask;
	logic txFb;
	logic [23:0] decCnt_q, decLimit;

	// only bit clock edges move the pattern, so gapped clocks just pause it
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			txClkP_q <= 1'b0;
			loadReqP_q <= 1'b0;
		end else begin
			txClkP_q <= txClkS;
			loadReqP_q <= loadPinS | ctrl_q.txLoad;
		end
	end
	assign txEdge = txClkS && !txClkP_q;
	assign loadEdge = (loadPinS | ctrl_q.txLoad) && !loadReqP_q;
	assign fire = txEdge && (txRun_q || txArm_q == 2'h1);
	assign lenMask = 32'hFFFF_FFFF >> (5'd31 - patLen_q);
	// tap A is fixed at length minus one, tap B is programmed
	assign txFb = ctrl_q.repMode ? txSr_q[patLen_q] : txSr_q[patLen_q] ^ txSr_q[tap_q];

	// load arms a three-edge countdown; the msb leaves on the third edge
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			txSr_q <= 32'h0000_0000;
			txArm_q <= 2'h0;
			txRun_q <= 1'b0;
			txData <= 1'b0;
		end else if (loadEdge) begin
			txSr_q <= patSet_q & lenMask;
			txArm_q <= `BERT_TX_LOAD_EDGES;
			txRun_q <= 1'b0;
		end else if (txEdge) begin
			if (txArm_q != 2'h0) txArm_q <= txArm_q - 2'h1;
			if (fire) begin
				txRun_q <= 1'b1;
				txData <= txSr_q[patLen_q] ^ inject;
				txSr_q <= {txSr_q[30:0], txFb} & lenMask;
			end
		end
	end

	// decade limit for the selected insertion rate
	always_comb begin
		unique case (errIns_q[2:0])
			3'h1: decLimit = `BERT_DEC1;
			3'h2: decLimit = `BERT_DEC2;
			3'h3: decLimit = `BERT_DEC3;
			3'h4: decLimit = `BERT_DEC4;
			3'h5: decLimit = `BERT_DEC5;
			3'h6: decLimit = `BERT_DEC6;
			3'h7: decLimit = `BERT_DEC7;
			default: decLimit = 24'hFF_FFFF;
		endcase
	end
	assign inject = singlePend_q || (errIns_q[2:0] != 3'h0 && decCnt_q == decLimit - 24'h1);

	// rate counter runs on transmitted bits only
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) decCnt_q <= 24'h00_0000;
		else if (errIns_q[2:0] == 3'h0 || (fire && decCnt_q >= decLimit - 24'h1)) decCnt_q <= 24'h00_0000;
		else if (fire) decCnt_q <= decCnt_q + 24'h1;
	end

	// single error request; a new request beats the consuming bit
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) singlePend_q <= 1'b0;
		else if (errIns_q[`BERT_EI_SINGLE]) singlePend_q <= 1'b1;
		else if (fire) singlePend_q <= 1'b0;
	end

	// ************************************************
	// receive synchroniser, independent of transmit state
	// ************************************************
	logic rxClkP_q, rxEdge, rxFb, bitErr;
	logic [6:0] good_q;
	logic [5:0] winCnt_q;
	logic [2:0] winErr_q;
	logic [31:0] hist_q;
	logic [6:0] syncNeed;

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) rxClkP_q <= 1'b0;
		else rxClkP_q <= rxClkS;
	end
	assign rxEdge = rxClkS && !rxClkP_q;
	// history fits the polynomial; constant zeros fit it too, constant ones only in repetitive mode
	assign rxFb = ctrl_q.repMode ? rxSr_q[patLen_q] : rxSr_q[patLen_q] ^ rxSr_q[tap_q];
	assign bitErr = rxDatS != rxFb;
	assign syncNeed = `BERT_SYNC_BASE + {2'h0, patLen_q} + 7'h1;

	// hunt feeds received bits in; once locked the register runs free
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) rxSr_q <= 32'h0000_0000;
		else if (rxEdge) rxSr_q <= {rxSr_q[30:0], rxState_q == BERT_LOCKED ? rxFb : rxDatS};
	end

	// hunt and lock; dense errors in a window drop lock, sparse ones do not
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rxState_q <= BERT_HUNT;
			good_q <= 7'h00;
			winCnt_q <= 6'h00;
			winErr_q <= 3'h0;
		end else if (ctrl_q.resync || !ctrl_q.syncEnable) begin
			rxState_q <= BERT_HUNT;
			good_q <= 7'h00;
		end else if (rxEdge) begin
			unique case (rxState_q)
				BERT_HUNT: begin
					good_q <= bitErr ? 7'h00 : good_q + 7'h1;
					winCnt_q <= 6'h00;
					winErr_q <= 3'h0;
					if (!bitErr && good_q + 7'h1 >= syncNeed) rxState_q <= BERT_LOCKED;
				end
				BERT_LOCKED: begin
					good_q <= 7'h00;
					winCnt_q <= winCnt_q + 6'h1;
					if (winCnt_q == `BERT_LOSS_WINDOW) winErr_q <= {2'h0, bitErr};
					else if (bitErr) winErr_q <= winErr_q + 3'h1;
					if (bitErr && winErr_q + 3'h1 >= `BERT_LOSS_ERRORS) rxState_q <= BERT_HUNT;
				end
			endcase
		end
	end
	assign rxSync = rxState_q == BERT_LOCKED;

	// raw history for the constant-stream flags
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			hist_q <= `BERT_RST_HIST;
			onesFlag_q <= 1'b0;
			zerosFlag_q <= 1'b0;
		end else begin
			if (rxEdge) hist_q <= {hist_q[30:0], rxDatS};
			onesFlag_q <= &hist_q;
			zerosFlag_q <= ~|hist_q;
		end
	end

	// ************************************************
	// bit and error counters
	// ************************************************
	logic lcPinP_q, lcEdge, errInc;
	logic [31:0] bitAcc_q, errAcc_q;

	// detector idles low like the pin, so reset release gives no false boundary
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) lcPinP_q <= 1'b0;
		else lcPinP_q <= lcPinS;
	end
	assign lcEdge = (lcPinS && !lcPinP_q) || ctrl_q.loadCount;
	assign errInc = rxEdge && rxSync && bitErr;

	// boundary snapshot includes the bit of that cycle, then restarts at zero
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			bitAcc_q <= 32'h0000_0000;
			bitCnt_q <= 32'h0000_0000;
		end else if (lcEdge) begin
			bitCnt_q <= bitAcc_q + {31'h0, rxEdge};
			bitAcc_q <= 32'h0000_0000;
		end else if (rxEdge) begin
			bitAcc_q <= bitAcc_q + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			errAcc_q <= 32'h0000_0000;
			errCnt_q <= 32'h0000_0000;
		end else if (lcEdge) begin
			errCnt_q <= errAcc_q + {31'h0, errInc};
			errAcc_q <= 32'h0000_0000;
		end else if (errInc) begin
			errAcc_q <= errAcc_q + 32'h1;
		end
	end

	// hsize is not decoded: only whole words are supported
	logic unusedBits;
	assign unusedBits = ^{hsize, haddr[31:8]};
endmodule : bert_top
`default_nettype wire

// [bert_monitor.sv]
// checker for bert_top: bus answers, field widths, timing of txData and rxSync against the bit clocks
// assumes: bound into bert_top, sees only its ports, one clock domain
`timescale 1ns/1ps
`default_nettype none
module bert_monitor (
	input wire logic ref_clk, // system clock
	input wire logic arst_n, // reset, active low
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic hready, // bus ready
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [31:0] hrdata, // read data
	input wire logic txBitClock, // tx bit clock
	input wire logic rxBitClock, // rx bit clock
	input wire logic txData, // serial out
	input wire logic rxSync // lock flag
);
	logic [3:0] txIdle_q; // cycles since tx clock high
	logic [3:0] rxIdle_q; // cycles since rx clock high
	// ************
	// helper counters
	// ************
	// saturating, so a stopped clock never wraps back into range
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) txIdle_q <= 4'hF;
		else if (txBitClock) txIdle_q <= 4'h0;
		else if (txIdle_q != 4'hF) txIdle_q <= txIdle_q + 4'h1;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rxIdle_q <= 4'hF;
		else if (rxBitClock) rxIdle_q <= 4'h0;
		else if (rxIdle_q != 4'hF) rxIdle_q <= rxIdle_q + 4'h1;
	end
	// ************
	// properties
	// ************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence rd_at(logic [7:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
	a_data_stands: assert property (!$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd_at(8'h24) |=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_len_width: assert property (rd_at(8'h04) |=> hrdata[31:5] == 27'h0) else $error("length upper bits set");
	a_tap_width: assert property (rd_at(8'h08) |=> hrdata[31:5] == 27'h0) else $error("tap upper bits set");
	a_ctrl_pulses: assert property (rd_at(8'h0C) |=> hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h0)
		else $error("control pulse bits read back");
	a_rate_width: assert property (rd_at(8'h10) |=> hrdata[31:3] == 29'h0) else $error("insert bits read back");
	a_status_flags: assert property (rd_at(8'h14) |=> hrdata[31:3] == 29'h0 && !(hrdata[1] && hrdata[2]))
		else $error("status flags inconsistent");
	a_status_sync: assert property (rd_at(8'h14) |=> hrdata[0] == $past(rxSync))
		else $error("status sync bit differs from rxSync");
	a_tx_on_edge: assert property ($changed(txData) |-> txIdle_q < 4'h8) else $error("txData moved off a bit clock");
	a_lock_on_edge: assert property ($rose(rxSync) |-> rxIdle_q < 4'h8) else $error("lock declared off a bit clock");
endmodule : bert_monitor
bind bert_top bert_monitor u_bert_monitor (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .txBitClock, .rxBitClock, .txData, .rxSync);
`default_nettype wire

// [bert_link_model.sv]
// loopback channel: one gappable bit clock for both paths, txData returned on rxData
// assumes: ref_clk at 40 MHz, bench raises run for as many bit periods as it wants
`timescale 1ns/1ps
`default_nettype none
module bert_link_model (
	input wire logic ref_clk, // system clock
	input wire logic run, // let bit periods pass
	input wire logic txData, // serial data from the tester
	output logic bitClock, // bit clock to both paths
	output logic rxData // looped data
);
	int phase;
	initial begin
		phase = 0;
		bitClock = 1'b0;
		rxData = 1'b0;
	end
	// 12 ref_clk per bit, 6 high and 6 low; stands low between bursts
	always @(posedge ref_clk) begin
		if (phase != 0 || run) begin
			phase <= (phase + 1) % 12;
			bitClock <= (phase < 6);
		end
	end
	// mid-bit capture keeps rxData far from the sampling rise
	always @(negedge bitClock) rxData <= txData;
endmodule : bert_link_model
`default_nettype wire

// [bert_top_tb.sv]
// self-checking bench for bert_top: register map, patterns, sync and counters
// assumes: bert_link_model loops txData to rxData with one bit clock for both paths
`timescale 1ns/1ps
`default_nettype none
`include "bert_cfg.svh"
module bert_top_tb;
	logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
	logic transmitLoad = 1'b0, loadCount = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	wire hreadyout, hresp, txData, rxSync, bitClk, rxData;
	wire [31:0] hrdata;
	int mismatches = 0, comparisons = 0;
	always #12.5 ref_clk = ~ref_clk;
	bert_top u_bert_top (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .transmitLoad, .loadCount, .txBitClock(bitClk),
		.rxBitClock(bitClk), .rxData, .txData, .rxSync);
	bert_link_model u_bert_link_model (.ref_clk, .run, .txData, .bitClock(bitClk), .rxData);
	// ************
	// shared tasks
	// ************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(x, e);
	endtask
	task automatic bits(input int n);
		run <= 1'b1;
		repeat (n) @(negedge bitClk);
		@(posedge ref_clk);
		run <= 1'b0;
	endtask
	task automatic lc_pin;
		loadCount <= 1'b1;
		repeat (6) @(posedge ref_clk);
		loadCount <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	// b7 is dropped first so the second write gives a rising edge when asked
	task automatic setup(input logic [31:0] pat, lenM1, tap, ctrl);
		wr(`BERT_OFS_PATSET, pat);
		wr(`BERT_OFS_PATLEN, lenM1);
		wr(`BERT_OFS_TAP, tap);
		wr(`BERT_OFS_ERRINS, 32'h0);
		wr(`BERT_OFS_CTRL, ctrl & 32'h7F);
		wr(`BERT_OFS_CTRL, ctrl);
		repeat (6) @(posedge ref_clk);
	endtask
	// reference shifter, msb first from the third bit clock rise
	task automatic tx_expect(input logic [31:0] pat, input int len, tap, input logic prbs, input int n, output int sAt);
		logic [31:0] s;
		s = pat;
		sAt = 0;
		run <= 1'b1;
		for (int i = 1; i <= n; i++) begin
			@(negedge bitClk);
			if (i >= 3) begin
				check({31'h0, txData}, {31'h0, s[len-1]});
				s = {s[30:0], s[len-1] ^ (prbs & s[tap])};
			end
			if (sAt == 0 && rxSync === 1'b1) sAt = i;
		end
		@(posedge ref_clk);
		run <= 1'b0;
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_regs;
		logic [7:0] a[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h0C, 8'h24, 8'h14};
		logic [31:0] w[7] = '{32'hA5C3_0F96, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h7, 32'hE, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
		logic [31:0] e[7] = '{32'hA5C3_0F96, 32'h1F, 32'h1F, 32'h7, 32'h2, 32'h0, 32'h0};
		for (int i = 0; i <= 36; i += 4) rd_chk(8'(i), 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(a[i], w[i]);
			rd_chk(a[i], e[i]);
		end
	endtask
	task automatic t_repeat;
		int s;
		setup(32'hB, 32'd3, 32'd0, 32'h81);
		tx_expect(32'hB, 4, 0, 1'b0, 14, s);
		setup(32'h1, 32'd0, 32'd0, 32'h81);
		tx_expect(32'h1, 1, 0, 1'b0, 10, s);
		setup(32'hFFFF_FFFF, 32'd31, 32'd0, 32'h83);
		tx_expect(32'hFFFF_FFFF, 32, 0, 1'b0, 140, s);
		check({31'h0, s >= 66}, 32'h1);
		rd_chk(`BERT_OFS_STATUS, 32'h3);
		rd_chk(`BERT_OFS_RXPAT, 32'hFFFF_FFFF);
	endtask
	// load from the pin after b7 is dropped, resync pulses in the control writes
	task automatic t_prbs;
		int s;
		setup(32'h1, 32'd6, 32'd5, 32'h06);
		transmitLoad <= 1'b1;
		repeat (8) @(posedge ref_clk);
		transmitLoad <= 1'b0;
		repeat (8) @(posedge ref_clk);
		tx_expect(32'h1, 7, 5, 1'b1, 70, s);
		check({31'h0, s >= 41 && s <= 60}, 32'h1);
	endtask
	task automatic t_count;
		wr(`BERT_OFS_ERRINS, 32'h2);
		lc_pin;
		bits(201);
		wr(`BERT_OFS_CTRL, 32'h0A);
		repeat (4) @(posedge ref_clk);
		rd_chk(`BERT_OFS_ERRCNT, 32'd2);
		rd_chk(`BERT_OFS_BITCNT, 32'd201);
		check({31'h0, rxSync}, 32'h1);
		wr(`BERT_OFS_ERRINS, 32'h8);
		rd_chk(`BERT_OFS_ERRINS, 32'h0);
		bits(50);
		lc_pin;
		rd_chk(`BERT_OFS_ERRCNT, 32'd1);
		rd_chk(`BERT_OFS_BITCNT, 32'd50);
		wr(`BERT_OFS_CTRL, 32'h0);
		wr(`BERT_OFS_ERRINS, 32'h2);
		lc_pin;
		check({31'h0, rxSync}, 32'h0);
		bits(200);
		lc_pin;
		rd_chk(`BERT_OFS_ERRCNT, 32'd0);
		rd_chk(`BERT_OFS_BITCNT, 32'd200);
		check({31'h0, rxSync}, 32'h0);
	endtask
	// constant zeros with sync enable low: no lock, zeros flag up, raw history shown
	task automatic t_zeros;
		int s;
		setup(32'h0, 32'd31, 32'd0, 32'h81);
		tx_expect(32'h0, 32, 0, 1'b0, 40, s);
		check(s, 32'h0);
		rd_chk(`BERT_OFS_STATUS, 32'h4);
		rd_chk(`BERT_OFS_RXPAT, 32'h0);
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs;
		t_repeat;
		t_prbs;
		t_count;
		t_zeros;
		report_and_stop;
	end
	// about 700 bit periods of 12 cycles plus bus traffic, with wide margin
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		report_and_stop;
	end
endmodule : bert_top_tb
`default_nettype wire
